// ===== src/irf_pkg.sv
// Package for the interrupt request pin front end.
// Assumes one clock (pclk) and an APB register slave in the same domain.
package irf_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] IRF_CFG_ADDR    = 8'h00;
   localparam logic [7:0] IRF_STATUS_ADDR = 8'h04;
   localparam logic [7:0] IRF_ACK_ADDR    = 8'h08;

   // ------------------------------------------------------------
   // Configuration fields
   // ------------------------------------------------------------
   localparam int IRF_CFG_EDGE_LSB  = 0;   // 4 bits, 1 = edge mode
   localparam int IRF_CFG_ACKC_BIT  = 4;   // line c acts as ack out a
   localparam int IRF_CFG_ACKD_BIT  = 5;   // line d acts as ack out b
   localparam int IRF_CFG_CASC_BIT  = 6;   // subordinate cascade mode
   localparam int IRF_CFG_W         = 7;
   localparam logic [6:0] IRF_CFG_RST = 7'h00;

   // ------------------------------------------------------------
   // Status fields
   // ------------------------------------------------------------
   localparam int IRF_ST_REQ_LSB = 0;      // 4 bits pending requests
   localparam int IRF_ST_NMI_BIT = 4;      // non-maskable pending

   // ------------------------------------------------------------
   // Vectors and widths
   // ------------------------------------------------------------
   localparam logic [7:0] IRF_NMI_VECTOR = 8'h02;
   localparam int         IRF_NLINES     = 4;

   // Acknowledge pulse length in cycles
   localparam logic [1:0] IRF_ACK_CYCLES = 2'h1;

endpackage : irf_pkg

// ===== src/irf_sync.sv
// Two-flop synchroniser bank for request pins.
// Assumes inputs may change at any time relative to pclk.
`timescale 1ns/100ps
module irf_sync
   import irf_pkg::*;
#(
   parameter int W = 5
)(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } irf_sync_t;

   irf_sync_t st_r;
   irf_sync_t st_nxt;

   // First stage feeds only the second stage
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign q = st_r.s2;

endmodule : irf_sync

// ===== src/irf_front_end.sv
// Interrupt request pin front end: NMI and four maskable request pins.
// Assumes pins driven by outside devices, APB master in pclk domain.
`timescale 1ns/100ps
module irf_front_end
   import irf_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic        nmi_pin,
   input  wire logic        request_line_a,
   input  wire logic        request_line_b_or_cascade_select,
   input  wire logic        request_line_c_or_ack_out_a_in,
   output logic             request_line_c_or_ack_out_a_out,
   output logic             request_line_c_or_ack_out_a_oe,
   input  wire logic        request_line_d_or_ack_out_b_in,
   output logic             request_line_d_or_ack_out_b_out,
   output logic             request_line_d_or_ack_out_b_oe,
   // Core side
   input  wire logic        instr_boundary,
   input  wire logic        ack_line_c,
   input  wire logic        ack_line_d,
   output logic             nmi_take,
   output logic [7:0]       nmi_vector,
   output logic [3:0]       req_level,
   output logic             cascade_mode,
   output logic             cascade_select
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [IRF_CFG_W-1:0] cfg;
      logic [3:0]           prev;
      logic [3:0]           pend;
      logic                 nmi_prev;
      logic                 nmi_pend;
      logic                 nmi_take;
      logic [1:0]           ack_c_cnt;
      logic [1:0]           ack_d_cnt;
      logic [31:0]          rdata;
   } irf_state_t;

   irf_state_t st_r;
   irf_state_t st_nxt;

   logic [4:0] sync_q;
   logic [3:0] req_sync;
   logic       nmi_sync;
   logic [3:0] edge_mode;
   logic       ack_c_en;
   logic       ack_d_en;
   logic       wr_en;
   logic       rd_en;
   logic       addr_ok;
   logic [3:0] clr_req;
   logic [3:0] pin_vec;
   logic [3:0] line_ok;

   assign pin_vec = {request_line_d_or_ack_out_b_in,
                     request_line_c_or_ack_out_a_in,
                     request_line_b_or_cascade_select,
                     request_line_a};

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   irf_sync #(.W(5)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({nmi_pin, pin_vec}),
      .q       (sync_q)
   );

   assign req_sync = sync_q[3:0];
   assign nmi_sync = sync_q[4];

   assign edge_mode = st_r.cfg[IRF_CFG_EDGE_LSB +: 4];
   assign ack_c_en  = st_r.cfg[IRF_CFG_ACKC_BIT];
   assign ack_d_en  = st_r.cfg[IRF_CFG_ACKD_BIT];
   assign cascade_mode = st_r.cfg[IRF_CFG_CASC_BIT];

   // Lines in ack role, and lines b to d in cascade mode, do not request
   assign line_ok = {~ack_d_en & ~cascade_mode,
                     ~ack_c_en & ~cascade_mode,
                     ~cascade_mode,
                     1'b1};

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign addr_ok = (paddr == IRF_CFG_ADDR) || (paddr == IRF_STATUS_ADDR)
                 || (paddr == IRF_ACK_ADDR);
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign clr_req = (wr_en && paddr == IRF_ACK_ADDR) ? pwdata[3:0] : 4'h0;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.prev     = req_sync;
      st_nxt.nmi_prev = nmi_sync;
      st_nxt.nmi_take = 1'b0;

      // Config holds no NMI mask bit by design
      if (wr_en && paddr == IRF_CFG_ADDR)
         st_nxt.cfg = pwdata[IRF_CFG_W-1:0];

      for (int i = 0; i < IRF_NLINES; i++)
      begin
         if (edge_mode[i])
         begin
            // Clear first so a same-cycle edge wins
            if (clr_req[i])
               st_nxt.pend[i] = 1'b0;
            if (req_sync[i] & ~st_r.prev[i] & line_ok[i])
               st_nxt.pend[i] = 1'b1;
         end
         else
            st_nxt.pend[i] = req_sync[i] & line_ok[i];
      end

      // NMI: set wins over take; take only on a boundary
      if (st_r.nmi_pend && instr_boundary)
      begin
         st_nxt.nmi_pend = 1'b0;
         st_nxt.nmi_take = 1'b1;
      end
      if (nmi_sync && !st_r.nmi_prev)
         st_nxt.nmi_pend = 1'b1;

      // Acknowledge pulses
      if (st_r.ack_c_cnt != 2'h0)
         st_nxt.ack_c_cnt = st_r.ack_c_cnt - 2'h1;
      if (st_r.ack_d_cnt != 2'h0)
         st_nxt.ack_d_cnt = st_r.ack_d_cnt - 2'h1;
      if (ack_line_c && ack_c_en && !cascade_mode)
         st_nxt.ack_c_cnt = IRF_ACK_CYCLES;
      if (ack_line_d && ack_d_en && !cascade_mode)
         st_nxt.ack_d_cnt = IRF_ACK_CYCLES;

      if (rd_en)
      begin
         st_nxt.rdata = 32'h0;
         case (paddr)
            IRF_CFG_ADDR:
               st_nxt.rdata[IRF_CFG_W-1:0] = st_r.cfg;
            IRF_STATUS_ADDR:
            begin
               st_nxt.rdata[IRF_ST_REQ_LSB +: 4] = st_r.pend;
               st_nxt.rdata[IRF_ST_NMI_BIT]      = st_r.nmi_pend;
            end
            default:
               st_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r     <= '0;
         st_r.cfg <= IRF_CFG_RST;
      end
      else
         st_r <= st_nxt;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Zero-wait slave keeps the master simple
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata  = st_r.rdata;

   assign nmi_take   = st_r.nmi_take;
   assign nmi_vector = IRF_NMI_VECTOR;
   assign req_level  = st_r.pend;
   assign cascade_select = cascade_mode & req_sync[1];

   assign request_line_c_or_ack_out_a_oe  = ack_c_en & ~cascade_mode;
   assign request_line_c_or_ack_out_a_out = (st_r.ack_c_cnt == 2'h0);
   assign request_line_d_or_ack_out_b_oe  = ack_d_en & ~cascade_mode;
   assign request_line_d_or_ack_out_b_out = (st_r.ack_d_cnt == 2'h0);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_nmi_rise;
      nmi_sync && !st_r.nmi_prev;
   endsequence

   property p_nmi_latch;
      @(posedge pclk) disable iff (!presetn)
      s_nmi_rise |=> st_r.nmi_pend || st_r.nmi_take;
   endproperty
   a_nmi_latch: assert property (p_nmi_latch)
      else $error("NMI edge not latched");

   property p_nmi_boundary;
      @(posedge pclk) disable iff (!presetn)
      nmi_take |-> $past(instr_boundary) && $past(st_r.nmi_pend);
   endproperty
   a_nmi_boundary: assert property (p_nmi_boundary)
      else $error("NMI taken off boundary");

   property p_nmi_vec;
      @(posedge pclk) disable iff (!presetn)
      nmi_take |-> nmi_vector == 8'h02;
   endproperty
   a_nmi_vec: assert property (p_nmi_vec)
      else $error("NMI vector wrong");

   property p_nmi_unmasked;
      @(posedge pclk) disable iff (!presetn)
      st_r.nmi_pend && instr_boundary |=> nmi_take;
   endproperty
   a_nmi_unmasked: assert property (p_nmi_unmasked)
      else $error("NMI not serviced");

   property p_level;
      @(posedge pclk) disable iff (!presetn)
      !edge_mode[0] |=> req_level[0] == $past(req_sync[0]);
   endproperty
   a_level: assert property (p_level)
      else $error("Level request not followed");

   property p_sync_delay;
      @(posedge pclk) disable iff (!presetn)
      request_line_a && !edge_mode[0] ##1 !edge_mode[0] [*2]
         |=> req_level[0] || $past(request_line_a, 1) == 1'b0;
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("Request not seen after sync");

   property p_edge;
      @(posedge pclk) disable iff (!presetn)
      edge_mode[0] && req_sync[0] && !st_r.prev[0] |=> req_level[0];
   endproperty
   a_edge: assert property (p_edge)
      else $error("Edge request lost");

   property p_edge_only;
      @(posedge pclk) disable iff (!presetn)
      edge_mode[0] && edge_mode[0] == $past(edge_mode[0])
         && !$past(req_level[0]) && req_level[0]
         |-> $past(req_sync[0]) && !$past(st_r.prev[0]);
   endproperty
   a_edge_only: assert property (p_edge_only)
      else $error("Edge set without edge");

   property p_ack;
      @(posedge pclk) disable iff (!presetn)
      ack_line_c && ack_c_en && !cascade_mode
         |=> !request_line_c_or_ack_out_a_out;
   endproperty
   a_ack: assert property (p_ack)
      else $error("Ack pulse missing");

   property p_cascade;
      @(posedge pclk) disable iff (!presetn)
      cascade_mode |-> !request_line_c_or_ack_out_a_oe
         && !request_line_d_or_ack_out_b_oe;
   endproperty
   a_cascade: assert property (p_cascade)
      else $error("Pins driven in cascade mode");

endmodule : irf_front_end

// ===== sim/irf_dev_model.sv
// Outside devices that drive the request pins.
// Assumes the bench asks for pin levels; ack pins resolve from enables.
`timescale 1ns/100ps
module irf_dev_model (
   input  wire logic       pclk,
   input  wire logic       nmi_cmd,
   input  wire logic [3:0] req_cmd,
   input  wire logic       c_out,
   input  wire logic       c_oe,
   input  wire logic       d_out,
   input  wire logic       d_oe,
   output logic            nmi_pin,
   output logic [3:0]      line
);
   logic [3:0] lvl_r;
   // Levels are held as long as the bench asks, never shortened
   always_ff @(posedge pclk)
   begin
      nmi_pin <= nmi_cmd;
      lvl_r   <= req_cmd;
   end
   // The device stops driving a pin that the block drives
   assign line[1:0] = lvl_r[1:0];
   assign line[2]   = c_oe ? c_out : lvl_r[2];
   assign line[3]   = d_oe ? d_out : lvl_r[3];
endmodule : irf_dev_model

// ===== sim/irf_front_end_tb.sv
// Self-checking bench for the request pin front end.
// Assumes 25 MHz pclk, APB master and the device model beside the block.
`timescale 1ns/100ps
module irf_front_end_tb
   import irf_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, nmi_vector;
   logic [31:0] pwdata, prdata, rv;
   logic nmi_cmd, nmi_pin, ib, ack_c, ack_d, nmi_take, cmode, csel, e;
   logic c_out, c_oe, d_out, d_oe;
   logic [3:0] req_cmd, line, req_level;
   int err_count, n_tests, cyc, k;
   // ------------------------------------------------------------
   // Block and outside devices
   // ------------------------------------------------------------
   irf_front_end dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nmi_pin(nmi_pin), .request_line_a(line[0]),
      .request_line_b_or_cascade_select(line[1]),
      .request_line_c_or_ack_out_a_in(line[2]),
      .request_line_c_or_ack_out_a_out(c_out),
      .request_line_c_or_ack_out_a_oe(c_oe),
      .request_line_d_or_ack_out_b_in(line[3]),
      .request_line_d_or_ack_out_b_out(d_out),
      .request_line_d_or_ack_out_b_oe(d_oe), .instr_boundary(ib),
      .ack_line_c(ack_c), .ack_line_d(ack_d), .nmi_take(nmi_take),
      .nmi_vector(nmi_vector), .req_level(req_level),
      .cascade_mode(cmode), .cascade_select(csel));
   irf_dev_model dev (.pclk(pclk), .nmi_cmd(nmi_cmd), .req_cmd(req_cmd),
      .c_out(c_out), .c_oe(c_oe), .d_out(d_out), .d_oe(d_oe),
      .nmi_pin(nmi_pin), .line(line));
   task automatic close_out;
      if (err_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(negedge pclk);
   endtask : w
   // Waits for pready as long as it takes; only the timeout ends a wait
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_nmi;
      apb(1'b1, IRF_CFG_ADDR, 32'h7F);
      @(posedge pclk);
      nmi_cmd <= 1'b1;
      @(posedge pclk);
      nmi_cmd <= 1'b0;
      k = 0;
      repeat (8) begin w(1); k += int'(nmi_take === 1'b1); end
      chk(k == 0, "nmi taken off boundary");
      apb(1'b0, IRF_STATUS_ADDR, 32'h0);
      chk(rv[IRF_ST_NMI_BIT] === 1'b1, "nmi not latched");
      @(posedge pclk);
      ib <= 1'b1;
      k = 0;
      repeat (4) begin w(1); k += int'(nmi_take === 1'b1); end
      chk(k == 1, "nmi take pulse");
      chk(nmi_vector === 8'h02, "nmi vector");
      @(posedge pclk);
      ib <= 1'b0;
      apb(1'b1, IRF_CFG_ADDR, 32'h0);
   endtask : t_nmi
   task automatic t_lines;
      apb(1'b0, 8'h0C, 32'h0);
      chk(e === 1'b1 && rv === 32'h0, "unmapped read");
      req_cmd <= 4'h1;
      w(2);
      chk(req_level === 4'h0, "request not synchronised");
      w(5);
      chk(req_level === 4'h1, "level request");
      req_cmd <= 4'h0;
      w(6);
      chk(req_level === 4'h0, "level follow");
      apb(1'b1, IRF_CFG_ADDR, 32'h1);
      req_cmd <= 4'h1;
      w(6);
      req_cmd <= 4'h0;
      w(6);
      chk(req_level === 4'h1, "edge latch");
      apb(1'b1, IRF_ACK_ADDR, 32'h1);
      w(2);
      chk(req_level === 4'h0, "edge clear");
   endtask : t_lines
   task automatic t_roles;
      apb(1'b1, IRF_CFG_ADDR, 32'h30);
      req_cmd <= 4'hC;
      w(6);
      chk(c_oe === 1'b1 && d_oe === 1'b1, "ack drive");
      chk(req_level === 4'h0, "ack pins request");
      @(posedge pclk);
      ack_c <= 1'b1;
      ack_d <= 1'b1;
      @(posedge pclk);
      ack_c <= 1'b0;
      ack_d <= 1'b0;
      k = 0;
      repeat (5)
      begin
         w(1);
         k += int'(c_out === 1'b0) + int'(d_out === 1'b0);
      end
      chk(k == 2, "ack low one cycle");
      apb(1'b1, IRF_CFG_ADDR, 32'h40);
      req_cmd <= 4'h2;
      w(6);
      chk(cmode === 1'b1 && csel === 1'b1, "cascade select");
      chk(req_level === 4'h0, "cascade request");
      req_cmd <= 4'h0;
   endtask : t_roles
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         $display("MISMATCH %0t timeout", $time);
         close_out();
      end
   end
   initial
   begin
      {presetn, psel, penable, pwrite, nmi_cmd, ib, ack_c, ack_d} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      req_cmd = 4'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, IRF_CFG_ADDR, 32'h0);
      chk(rv === 32'h0, "cfg reset value");
      t_nmi();
      t_lines();
      t_roles();
      close_out();
   end
endmodule : irf_front_end_tb
